// [include/fps_pkg.sv]
// Package for the flash program/erase sequencer: register map, fields, states, carriers.
// Assumes a byte-wide register port and a flash macro that takes level commands.
package fps_pkg;

  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [1:0] FPS_OFS_CTRL1 = 2'h0;
  localparam logic [1:0] FPS_OFS_CTRL2 = 2'h1;
  localparam logic [1:0] FPS_OFS_EBS1  = 2'h2;
  localparam logic [1:0] FPS_OFS_EBS2  = 2'h3;

  localparam logic [7:0] FPS_RST_CTRL1 = 8'h00;
  localparam logic [7:0] FPS_RST_CTRL2 = 8'h00;
  localparam logic [7:0] FPS_RST_EBS   = 8'h00;

  // flash_control_reg_one fields
  localparam int FPS_B_PROG  = 0;
  localparam int FPS_B_ERASE = 1;
  localparam int FPS_B_PV    = 2;
  localparam int FPS_B_EV    = 3;
  localparam int FPS_B_SWE   = 6;
  // flash_control_reg_two fields
  localparam int FPS_B_PSU   = 0;
  localparam int FPS_B_ESU   = 1;
  localparam int FPS_B_FULL  = 6;
  localparam int FPS_B_FLASH_ERROR_FLAG  = 7;

  // ***************************************************
  // Flash geometry
  // ***************************************************
  localparam int FPS_AW        = 16;
  localparam int FPS_LINE      = 32;
  localparam int FPS_IDXW      = 5;
  localparam int FPS_ROWW      = FPS_AW - FPS_IDXW;
  localparam int FPS_NBLK      = 16;
  localparam logic [5:0] FPS_LINE_CNT = 6'h20;
  localparam logic [15:0] FPS_BLANK16 = 16'hFFFF;

  // ***************************************************
  // States and carriers
  // ***************************************************
  typedef enum logic [2:0] {
    FPS_S_IDLE  = 3'b000,
    FPS_S_PROG  = 3'b001,
    FPS_S_ERASE = 3'b010,
    FPS_S_PVER  = 3'b011,
    FPS_S_EVER  = 3'b100
  } fps_state_t;

  typedef struct packed {
    logic                 prog;
    logic                 erase;
    logic                 pverify;
    logic                 everify;
    logic [FPS_NBLK-1:0]  blocks;
    logic [FPS_ROWW-1:0]  row;
  } fps_mac_cmd_t;

endpackage

// [src/fps_latch_ram.sv]
// Line latch memory holding the bytes of one program transfer.
// Assumes one write port and one read port on the same clock; read data registered.
`timescale 1ns/10ps
module fps_latch_ram #(
  parameter int DW    = 8,
  parameter int DEPTH = 32,
  parameter int IW    = 5
) (
  input  wire logic          core_clk,
  input  wire logic          wr_en,
  input  wire logic [IW-1:0] wr_idx,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [IW-1:0] rd_idx,
  output logic      [DW-1:0] rd_data
);

  // ***************************************************
  // Storage
  // ***************************************************
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end

endmodule

// [src/fps_sequencer.sv]
// Flash program/erase sequencer: control registers, line latch, mode state machine.
// Assumes software keeps all wait times and the watchdog; the macro obeys mac_cmd levels.
`timescale 1ns/10ps

// Function
// - Four modes only, each needing write enable; program/erase entered by setup and mode bits together, verify by mode bit without setup.
// - Device latches address and data of each transfer byte for the pulse; the code keeps each byte's data and index but only the first byte's row.
// - Program setup, wait, program bit; device programs while bit is set.
// - Verify reads return the dummy-written address's data, 16 bits wide.
// - Erase setup, wait, erase bit; device erases while bit is set.
// - Erase starts without any preprogramming of the block.
// - Error flag aborts program/erase and blocks re-entry; verify still allowed.
// - Both block select registers zero means every block is erase protected.
// - Write enable clear ignores program and erase bits.
module fps_sequencer (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic [1:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [7:0]                   reg_rdata,
  input  wire logic [fps_pkg::FPS_AW-1:0]   fl_addr,
  input  wire logic [7:0]                   fl_wdata,
  input  wire logic                         fl_wr,
  input  wire logic                         fl_rd,
  output logic      [15:0]                  fl_rdata,
  input  wire logic                         err_event,
  output fps_pkg::fps_mac_cmd_t             mac_cmd,
  output logic      [fps_pkg::FPS_AW-1:0]   mac_raddr,
  input  wire logic [15:0]                  mac_rdata,
  input  wire logic [fps_pkg::FPS_IDXW-1:0] mac_idx,
  output logic      [7:0]                   mac_byte
);
  import fps_pkg::*;

  // ***************************************************
  // Registers
  // ***************************************************
  logic [7:0]          ctrl1_reg, ctrl1_next;
  logic [1:0]          setup_reg, setup_next;
  logic                flash_error_flag_reg, flash_error_flag_next;
  logic [7:0]          ebs1_reg, ebs1_next;
  logic [7:0]          ebs2_reg, ebs2_next;
  logic [7:0]          rdata_reg, rdata_next;
  logic                software_write_enable;
  logic                fl_busy;
  fps_state_t          state_reg, state_next;
  logic [5:0]          cnt_reg, cnt_next;

  assign software_write_enable     = ctrl1_reg[FPS_B_SWE];
  assign fl_busy = (state_reg == FPS_S_PROG) || (state_reg == FPS_S_ERASE);

  always_comb begin
    ctrl1_next = ctrl1_reg;
    setup_next = setup_reg;
    ebs1_next  = ebs1_reg;
    ebs2_next  = ebs2_reg;
    flash_error_flag_next  = flash_error_flag_reg;
    rdata_next = rdata_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        FPS_OFS_CTRL1: begin
          ctrl1_next = reg_wdata & 8'h4F;
        end
        FPS_OFS_CTRL2: begin
          setup_next = reg_wdata[1:0];
        end
        FPS_OFS_EBS1: begin
          ebs1_next = reg_wdata;
        end
        FPS_OFS_EBS2: begin
          ebs2_next = reg_wdata;
        end
      endcase
    end
    // Runaway during a pulse: sticky until reset, registers kept as written
    if (fl_busy && (err_event || fl_rd)) begin
      flash_error_flag_next = 1'b1;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        FPS_OFS_CTRL1: begin
          rdata_next = ctrl1_reg;
        end
        FPS_OFS_CTRL2: begin
          rdata_next = {flash_error_flag_reg, (cnt_reg == FPS_LINE_CNT), 4'h0, setup_reg};
        end
        FPS_OFS_EBS1: begin
          rdata_next = ebs1_reg;
        end
        FPS_OFS_EBS2: begin
          rdata_next = ebs2_reg;
        end
      endcase
    end else begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_reg <= FPS_RST_CTRL1;
      setup_reg <= FPS_RST_CTRL2[1:0];
      flash_error_flag_reg  <= 1'b0;
      ebs1_reg  <= FPS_RST_EBS;
      ebs2_reg  <= FPS_RST_EBS;
      rdata_reg <= 8'h00;
    end else begin
      ctrl1_reg <= ctrl1_next;
      setup_reg <= setup_next;
      flash_error_flag_reg  <= flash_error_flag_next;
      ebs1_reg  <= ebs1_next;
      ebs2_reg  <= ebs2_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ***************************************************
  // Mode state machine
  // ***************************************************
  logic [3:0] mode_bits;
  logic       one_mode;
  logic       blk_any;
  logic       err_now;

  assign mode_bits = {ctrl1_reg[FPS_B_EV], ctrl1_reg[FPS_B_PV],
                      ctrl1_reg[FPS_B_ERASE], ctrl1_reg[FPS_B_PROG]};
  assign one_mode  = $onehot(mode_bits);
  // Next values, so erase never outlives a select cleared to zero
  assign blk_any   = (ebs1_next != 8'h00) || (ebs2_next != 8'h00);
  assign err_now   = flash_error_flag_reg || flash_error_flag_next;

  // Mode follows the bits level by level; pulse length is timed by software
  always_comb begin
    state_next = FPS_S_IDLE;
    if (software_write_enable && one_mode) begin
      if (mode_bits[0] && setup_reg[FPS_B_PSU] && !err_now) begin
        state_next = FPS_S_PROG;
      end else if (mode_bits[1] && setup_reg[FPS_B_ESU] && blk_any && !err_now) begin
        state_next = FPS_S_ERASE;
      end else if (mode_bits[2]) begin
        state_next = FPS_S_PVER;
      end else if (mode_bits[3]) begin
        state_next = FPS_S_EVER;
      end
    end
  end

  // ***************************************************
  // Line latch and verify address
  // ***************************************************
  logic                   lat_wr;
  logic                   dummy_wr;
  logic [FPS_ROWW-1:0]    row_reg, row_next;
  logic [FPS_AW-1:0]      vaddr_reg, vaddr_next;
  logic [15:0]            frd_reg, frd_next;

  // Transfers only count while no mode acts, so a stray write mid-pulse is dropped
  assign lat_wr   = fl_wr && software_write_enable && (state_reg == FPS_S_IDLE);
  assign dummy_wr = fl_wr && ((state_reg == FPS_S_PVER) || (state_reg == FPS_S_EVER));

  always_comb begin
    cnt_next   = cnt_reg;
    row_next   = row_reg;
    vaddr_next = vaddr_reg;
    frd_next   = frd_reg;
    if (!software_write_enable) begin
      cnt_next = 6'h00;
    end else if (lat_wr) begin
      if (cnt_reg == 6'h00 || cnt_reg == FPS_LINE_CNT) begin
        row_next = fl_addr[FPS_AW-1:FPS_IDXW];
        cnt_next = 6'h01;
      end else begin
        cnt_next = cnt_reg + 6'h01;
      end
    end
    if (dummy_wr) begin
      vaddr_next = fl_addr;
    end
    if (fl_rd) begin
      if (state_reg == FPS_S_PVER || state_reg == FPS_S_EVER) begin
        frd_next = mac_rdata;
      end else if (software_write_enable) begin
        frd_next = FPS_BLANK16;
      end else begin
        frd_next = mac_rdata;
      end
    end
  end

  assign mac_raddr = ((state_reg == FPS_S_PVER) || (state_reg == FPS_S_EVER)) ?
                     vaddr_reg : fl_addr;
  assign fl_rdata  = frd_reg;

  fps_latch_ram #(
    .DW    (8),
    .DEPTH (FPS_LINE),
    .IW    (FPS_IDXW)
  ) u_latch (
    .core_clk (core_clk),
    .wr_en    (lat_wr),
    .wr_idx   (fl_addr[FPS_IDXW-1:0]),
    .wr_data  (fl_wdata),
    .rd_idx   (mac_idx),
    .rd_data  (mac_byte)
  );

  // ***************************************************
  // Macro command
  // ***************************************************
  fps_mac_cmd_t cmd_reg, cmd_next;

  // Erase is driven straight from the erase state; no preprogram pass exists
  always_comb begin
    cmd_next         = '0;
    cmd_next.prog    = (state_next == FPS_S_PROG);
    cmd_next.erase   = (state_next == FPS_S_ERASE);
    cmd_next.pverify = (state_next == FPS_S_PVER);
    cmd_next.everify = (state_next == FPS_S_EVER);
    cmd_next.blocks  = {ebs2_next, ebs1_next};
    cmd_next.row     = row_next;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= FPS_S_IDLE;
      cnt_reg   <= 6'h00;
      row_reg   <= '0;
      vaddr_reg <= '0;
      frd_reg   <= 16'h0000;
      cmd_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      row_reg   <= row_next;
      vaddr_reg <= vaddr_next;
      frd_reg   <= frd_next;
      cmd_reg   <= cmd_next;
    end
  end

  assign mac_cmd = cmd_reg;

  // ***************************************************
  // Assertions
  // ***************************************************
  property p_mode_entry;
    @(posedge core_clk) disable iff (!rst_n)
    (state_reg == FPS_S_PROG) |->
      $past(ctrl1_reg[FPS_B_PROG]) && $past(setup_reg[FPS_B_PSU]) && $past(software_write_enable);
  endproperty
  a_mode_entry: assert property (p_mode_entry) else $error("Program mode without its bits");

  property p_latch_count;
    @(posedge core_clk) disable iff (!rst_n)
    (lat_wr && cnt_reg != 6'h00 && cnt_reg != FPS_LINE_CNT && software_write_enable)
      |=> (cnt_reg == $past(cnt_reg) + 6'h01);
  endproperty
  a_latch_count: assert property (p_latch_count) else $error("Latch count did not advance");

  property p_latch_row;
    @(posedge core_clk) disable iff (!rst_n)
    (lat_wr && cnt_reg == 6'h00) |=> (row_reg == $past(fl_addr[FPS_AW-1:FPS_IDXW]));
  endproperty
  a_latch_row: assert property (p_latch_row) else $error("Row not latched on first byte");

  property p_verify_read;
    @(posedge core_clk) disable iff (!rst_n)
    (fl_rd && state_reg == FPS_S_EVER) |-> (mac_raddr == vaddr_reg) ##1
      (fl_rdata == $past(mac_rdata));
  endproperty
  a_verify_read: assert property (p_verify_read) else $error("Verify read wrong source");

  property p_erase_direct;
    @(posedge core_clk) disable iff (!rst_n)
    (state_reg == FPS_S_ERASE) |-> (mac_cmd.erase && !mac_cmd.prog);
  endproperty
  a_erase_direct: assert property (p_erase_direct) else $error("Erase not driven directly");

  property p_error_abort;
    @(posedge core_clk) disable iff (!rst_n)
    (fl_busy && err_event) |=> (flash_error_flag_reg && !fl_busy) ##1 !fl_busy;
  endproperty
  a_error_abort: assert property (p_error_abort) else $error("Error did not abort mode");

  property p_no_protect_erase;
    @(posedge core_clk) disable iff (!rst_n)
    (ebs1_reg == 8'h00 && ebs2_reg == 8'h00) |-> (state_reg != FPS_S_ERASE);
  endproperty
  a_no_protect_erase: assert property (p_no_protect_erase) else $error("Erase of protected block");

  property p_swe_protect;
    @(posedge core_clk) disable iff (!rst_n)
    !software_write_enable |=> !mac_cmd.prog && !mac_cmd.erase;
  endproperty
  a_swe_protect: assert property (p_swe_protect) else $error("Pulse while write disabled");

  property p_one_mode;
    @(posedge core_clk) disable iff (!rst_n)
    $onehot0({mac_cmd.prog, mac_cmd.erase, mac_cmd.pverify, mac_cmd.everify});
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("Two modes at once");

  property p_prog_follows;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(mac_cmd.prog) |-> $past(ctrl1_reg[FPS_B_PROG]) && $past(setup_reg[FPS_B_PSU]);
  endproperty
  a_prog_follows: assert property (p_prog_follows) else $error("Program pulse without request");

  property p_erase_follows;
    @(posedge core_clk) disable iff (!rst_n)
    (state_reg == FPS_S_ERASE && !ctrl1_next[FPS_B_ERASE]) |-> ##2 !mac_cmd.erase;
  endproperty
  a_erase_follows: assert property (p_erase_follows) else $error("Erase outlived its bit");

  c_prog:  cover property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == FPS_S_PROG) ##[1:100] (state_reg == FPS_S_PVER));
  c_erase: cover property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == FPS_S_ERASE) ##[1:50] (state_reg == FPS_S_EVER));
  c_full:  cover property (@(posedge core_clk) disable iff (!rst_n)
    (cnt_reg == FPS_LINE_CNT));
  c_flash_error_flag:  cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(flash_error_flag_reg) ##[1:40] (state_reg == FPS_S_PVER));

endmodule

// [verif/fps_sequencer_test.sv]
// Self-checking bench for the flash program/erase sequencer.
// Assumes the sequencer stands alone; the bench plays the flash macro read path.
`timescale 1ns/10ps
module fps_sequencer_test;
  import fps_pkg::*;
  // ***************************************************
  // Signals
  // ***************************************************
  logic                core_clk;
  logic                rst_n;
  logic [1:0]          reg_addr;
  logic [7:0]          reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [7:0]          reg_rdata;
  logic [FPS_AW-1:0]   fl_addr;
  logic [7:0]          fl_wdata;
  logic                fl_wr;
  logic                fl_rd;
  logic [15:0]         fl_rdata;
  logic                err_event;
  fps_mac_cmd_t        mac_cmd;
  logic [FPS_AW-1:0]   mac_raddr;
  logic [15:0]         mac_rdata;
  logic [FPS_IDXW-1:0] mac_idx;
  logic [7:0]          mac_byte;
  logic [7:0]          q_reg[$];
  logic [15:0]         q_fl[$];
  logic [7:0]          q_byte[$];
  fps_mac_cmd_t        q_cmd[$];
  logic                mc, ic, rr_d, fr_d, mc_d, ic_d;
  logic [15:0]         ebs;
  logic [FPS_ROWW-1:0] exp_row;
  logic [7:0]          lb[32];
  logic [31:0]         seed;
  logic [31:0]         r;
  int                  fails;
  int                  n_tests;

  // Macro model: data is a fixed scramble of the address, so a stale address shows
  assign mac_rdata = mac_raddr ^ 16'h5A5A;

  fps_sequencer dut_u (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .fl_addr   (fl_addr),
    .fl_wdata  (fl_wdata),
    .fl_wr     (fl_wr),
    .fl_rd     (fl_rd),
    .fl_rdata  (fl_rdata),
    .err_event (err_event),
    .mac_cmd   (mac_cmd),
    .mac_raddr (mac_raddr),
    .mac_rdata (mac_rdata),
    .mac_idx   (mac_idx),
    .mac_byte  (mac_byte)
  );

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  // ***************************************************
  // Tasks
  // ***************************************************
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a == FPS_OFS_EBS1) ebs[7:0] = d;
    if (a == FPS_OFS_EBS2) ebs[15:8] = d;
  endtask

  task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    q_reg.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic fw(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    fl_addr <= a;
    fl_wdata <= d;
    fl_wr <= 1'b1;
    @(posedge core_clk);
    fl_wr <= 1'b0;
  endtask

  task automatic fr(input logic [15:0] a, input logic [15:0] e);
    @(posedge core_clk);
    fl_addr <= a;
    fl_rd <= 1'b1;
    q_fl.push_back(e);
    @(posedge core_clk);
    fl_rd <= 1'b0;
  endtask

  task automatic mode(input logic p, input logic e, input logic pv, input logic ev);
    fps_mac_cmd_t c;
    c = '{p, e, pv, ev, ebs, exp_row};
    @(posedge core_clk);
    q_cmd.push_back(c);
    mc <= 1'b1;
    @(posedge core_clk);
    mc <= 1'b0;
  endtask

  task automatic chk_b(input logic [4:0] i, input logic [7:0] e);
    @(posedge core_clk);
    mac_idx <= i;
    ic <= 1'b1;
    q_byte.push_back(e);
    @(posedge core_clk);
    ic <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    ebs = 16'h0000;
    exp_row = '0;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    cmp({24'h000000, g}, {24'h000000, e});
  endtask

  task automatic cmp_fl(input logic [15:0] g, input logic [15:0] e);
    cmp({16'h0000, g}, {16'h0000, e});
  endtask

  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    cmp({24'h000000, g}, {24'h000000, e});
  endtask

  task automatic cmp_cmd(input fps_mac_cmd_t g, input fps_mac_cmd_t e);
    cmp({1'b0, g}, {1'b0, e});
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ***************************************************
  // Checking
  // ***************************************************
  // Outputs are judged at the falling edge, well clear of the launching edge
  always @(posedge core_clk) begin
    rr_d <= reg_rd;
    fr_d <= fl_rd;
    mc_d <= mc;
    ic_d <= ic;
  end

  always @(negedge core_clk) begin
    if (rr_d) cmp_reg(reg_rdata, q_reg.pop_front());
    if (fr_d) cmp_fl(fl_rdata, q_fl.pop_front());
    if (ic_d) cmp_byte(mac_byte, q_byte.pop_front());
    if (mc_d) cmp_cmd(mac_cmd, q_cmd.pop_front());
  end

  initial begin
    repeat (4000) @(posedge core_clk);
    fails++;
    finish_test();
  end

  // ***************************************************
  // Sequence
  // ***************************************************
  initial begin
    {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {fl_addr, fl_wdata, fl_wr, fl_rd, err_event, mac_idx} = '0;
    {mc, ic, rr_d, fr_d, mc_d, ic_d} = '0;
    {fails, n_tests} = '0;
    ebs = 16'h0000;
    exp_row = '0;
    seed = 32'h00000041;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_reg(FPS_OFS_CTRL1, FPS_RST_CTRL1);
    rd_reg(FPS_OFS_CTRL2, FPS_RST_CTRL2);
    rd_reg(FPS_OFS_EBS1, FPS_RST_EBS);
    rd_reg(FPS_OFS_EBS2, FPS_RST_EBS);
    wr_reg(FPS_OFS_CTRL2, 8'h01);
    wr_reg(FPS_OFS_CTRL1, 8'h01);
    mode(1'b0, 1'b0, 1'b0, 1'b0);
    wr_reg(FPS_OFS_CTRL1, 8'hFF);
    mode(1'b0, 1'b0, 1'b0, 1'b0);
    rd_reg(FPS_OFS_CTRL1, 8'h4F);
    wr_reg(FPS_OFS_CTRL1, 8'h00);
    fr(16'h2468, 16'h2468 ^ 16'h5A5A);
    // Erase entry with a fresh, never programmed block
    wr_reg(FPS_OFS_CTRL2, 8'h02);
    wr_reg(FPS_OFS_CTRL1, 8'h42);
    mode(1'b0, 1'b0, 1'b0, 1'b0);
    r = xs();
    wr_reg(FPS_OFS_EBS1, r[7:0] | 8'h01);
    wr_reg(FPS_OFS_EBS2, r[15:8]);
    mode(1'b0, 1'b1, 1'b0, 1'b0);
    wr_reg(FPS_OFS_CTRL1, 8'h40);
    wr_reg(FPS_OFS_CTRL2, 8'h00);
    // Full aligned line, tail padded with all-ones bytes
    for (int i = 0; i < 32; i++) begin
      r = xs();
      lb[i] = (i > 27) ? 8'hFF : r[7:0];
      fw(16'h1240 + 16'(i), lb[i]);
    end
    exp_row = 11'h092;
    rd_reg(FPS_OFS_CTRL2, 8'h40);
    wr_reg(FPS_OFS_CTRL2, 8'h01);
    wr_reg(FPS_OFS_CTRL1, 8'h41);
    mode(1'b1, 1'b0, 1'b0, 1'b0);
    fw(16'h1240, ~lb[0]);
    for (int i = 0; i < 32; i++) chk_b(5'(i), lb[i]);
    wr_reg(FPS_OFS_CTRL1, 8'h40);
    wr_reg(FPS_OFS_CTRL2, 8'h00);
    wr_reg(FPS_OFS_CTRL1, 8'h44);
    mode(1'b0, 1'b0, 1'b1, 1'b0);
    fw(16'h3456, 8'hFF);
    fr(16'h0000, 16'h3456 ^ 16'h5A5A);
    wr_reg(FPS_OFS_CTRL1, 8'h48);
    mode(1'b0, 1'b0, 1'b0, 1'b1);
    fw(16'h789A, 8'hFF);
    fr(16'h1240, 16'h789A ^ 16'h5A5A);
    wr_reg(FPS_OFS_CTRL1, 8'h40);
    fr(16'h789A, 16'hFFFF);
    // Runaway during erase: abort, sticky flag, verify still reachable
    wr_reg(FPS_OFS_CTRL2, 8'h02);
    wr_reg(FPS_OFS_CTRL1, 8'h42);
    mode(1'b0, 1'b1, 1'b0, 1'b0);
    @(posedge core_clk);
    err_event <= 1'b1;
    @(posedge core_clk);
    err_event <= 1'b0;
    mode(1'b0, 1'b0, 1'b0, 1'b0);
    rd_reg(FPS_OFS_CTRL2, 8'hC2);
    wr_reg(FPS_OFS_CTRL1, 8'h40);
    wr_reg(FPS_OFS_CTRL1, 8'h42);
    mode(1'b0, 1'b0, 1'b0, 1'b0);
    wr_reg(FPS_OFS_CTRL2, 8'h01);
    wr_reg(FPS_OFS_CTRL1, 8'h41);
    mode(1'b0, 1'b0, 1'b0, 1'b0);
    wr_reg(FPS_OFS_CTRL2, 8'h00);
    wr_reg(FPS_OFS_CTRL1, 8'h44);
    mode(1'b0, 1'b0, 1'b1, 1'b0);
    // Second reset, then a flash read during erase trips the flag
    do_reset();
    wr_reg(FPS_OFS_EBS2, 8'h80);
    wr_reg(FPS_OFS_CTRL1, 8'h40);
    wr_reg(FPS_OFS_CTRL2, 8'h02);
    wr_reg(FPS_OFS_CTRL1, 8'h42);
    mode(1'b0, 1'b1, 1'b0, 1'b0);
    fr(16'h0100, 16'hFFFF);
    mode(1'b0, 1'b0, 1'b0, 1'b0);
    rd_reg(FPS_OFS_CTRL2, 8'h82);
    finish_test();
  end
endmodule
